// ---- core/scfg_pkg.sv ----
// Operation
// - only 16-bit instructions; length select bit resets to one, host keeps it
// - soft reset bit at one restores all other registers to defaults
// - bit order zero: shift msb first, address decrements across bytes
// - bit order one: shift lsb first, address increments across bytes
// - pin mode zero: reads on the shared data pin, output pin floats
// - pin mode one: reads on the dedicated output pin, writes on shared pin
// - read-only 8-bit variant identification register; writes ignored
// - readback select zero returns buffer register contents
// - readback select one returns active register contents
package scfg_pkg;
  localparam int ADDR_W = 13;
  localparam int INSTR_LEN = 16;
  // register offsets
  localparam logic [12:0] ADR_PORT_CFG = 13'h000;
  localparam logic [12:0] ADR_VARIANT_ID = 13'h003;
  localparam logic [12:0] ADR_READBACK_SEL = 13'h004;
  localparam logic [12:0] ADR_OSC_DIV = 13'h1e0;
  localparam logic [12:0] ADR_CLK_IN_SEL = 13'h1e1;
  localparam logic [12:0] ADR_PWRDN_SYNC = 13'h230;
  localparam logic [12:0] ADR_SYS_SPARE = 13'h231;
  localparam logic [12:0] ADR_COMMIT = 13'h232;
  // reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_READBACK_SEL = 8'h00;
  localparam logic [7:0] RST_OSC_DIV = 8'h02;
  localparam logic [7:0] RST_CLK_IN_SEL = 8'h00;
  localparam logic [7:0] RST_PWRDN_SYNC = 8'h00;
  // field positions
  localparam int BIT_PIN_MODE = 0;
  localparam int BIT_LSB_FIRST = 1;
  localparam int BIT_SOFT_RST = 2;
  localparam int BIT_LONG_INSTR = 3;
  localparam int BIT_RB_ACTIVE = 0;
  localparam int BIT_COMMIT = 0;
  // instruction fields
  localparam int INS_RD = 15;
  localparam int INS_LEN_HI = 14;
  localparam int INS_LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  // arbitrary variant code, not any real part
  localparam logic [7:0] VARIANT_ID_DEF = 8'h5a;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } scfg_state_type;
endpackage

// ---- core/scfg_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module scfg_sync (
  input wire logic CLK_I,     // system clock
  input wire logic RST_N_I,   // sync reset, active low
  input wire logic sclk_i,    // serial clock pin
  input wire logic cs_n_i,    // chip select pin, active low
  input wire logic sdio_i,    // shared data pin level
  output logic cs_n_o,        // synchronised select
  output logic sdio_o,        // synchronised data
  output logic rise_o,        // serial clock rising edge pulse
  output logic fall_o         // serial clock falling edge pulse
);
  logic [2:0] meta_r, meta_nxt;
  logic [2:0] sync_r, sync_nxt;
  logic sclk_d_r, sclk_d_nxt;

  // two flops per pin, plus a third on the serial clock for edge detect; the first stage never feeds logic
  always_comb begin
    meta_nxt = {sclk_i, cs_n_i, sdio_i};
    sync_nxt = meta_r;
    sclk_d_nxt = sync_r[2];
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      // reset to the idle pin levels so no false clock edge follows reset
      meta_r <= 3'h2;
      sync_r <= 3'h2;
      sclk_d_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      sclk_d_r <= sclk_d_nxt;
    end
  end

  assign cs_n_o = sync_r[1];
  assign sdio_o = sync_r[0];
  assign rise_o = sync_r[2] & ~sclk_d_r;
  assign fall_o = ~sync_r[2] & sclk_d_r;
endmodule
`default_nettype wire

// ---- core/scfg_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module scfg_port (
  input wire logic CLK_I,       // system clock, 50 MHz
  input wire logic RST_N_I,     // sync reset, active low
  input wire logic SCLK_I,      // serial clock from host
  input wire logic CS_N_I,      // chip select, active low
  input wire logic SDIO_I,      // shared data pin, input side
  output logic SDIO_O,          // shared data pin, output value
  output logic SDIO_OE_O,       // shared data pin drive enable
  output logic SDO_O,           // dedicated read out pin value
  output logic SDO_OE_O,        // dedicated read out pin enable
  output logic [7:0] OSC_DIV_O, // active oscillator divide ratio
  output logic [7:0] CLK_IN_O,  // active clock input select/power
  output logic [7:0] PWRDN_O    // active power-down and sync
);
  logic cs_n_s, sdio_s, sclk_rise, sclk_fall;

  scfg_sync u_sync (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .sclk_i(SCLK_I),
    .cs_n_i(CS_N_I),
    .sdio_i(SDIO_I),
    .cs_n_o(cs_n_s),
    .sdio_o(sdio_s),
    .rise_o(sclk_rise),
    .fall_o(sclk_fall)
  );

  scfg_pkg::scfg_state_type state_r, state_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [2:0] bcnt_r, bcnt_nxt;
  logic rd_r, rd_nxt;
  logic [1:0] len_r, len_nxt;
  logic [1:0] bidx_r, bidx_nxt;
  logic [12:0] addr_r, addr_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic [7:0] pcfg_r, pcfg_nxt;
  logic [7:0] rbsel_r, rbsel_nxt;
  logic [7:0] bdiv_r, bdiv_nxt, bclk_r, bclk_nxt, bpwr_r, bpwr_nxt;
  logic [7:0] adiv_r, adiv_nxt, aclk_r, aclk_nxt, apwr_r, apwr_nxt;
  logic commit_r, commit_nxt;
  logic lsb_first;
  logic [15:0] ins;
  logic [7:0] rx;

  // next address in a multi-byte transfer
  function automatic logic [12:0] step_addr(input logic [12:0] a,
                                            input logic lsb);
    step_addr = lsb ? 13'(a + 13'h001) : 13'(a - 13'h001);
  endfunction

  // register read view, buffered or active copy
  function automatic logic [7:0] rd_byte(input logic [12:0] a,
      input logic act, input logic [7:0] pc, input logic [7:0] rb,
      input logic [7:0] bd, input logic [7:0] bc, input logic [7:0] bp,
      input logic [7:0] ad, input logic [7:0] ac, input logic [7:0] ap,
      input logic cm);
    case (a)
      scfg_pkg::ADR_PORT_CFG: rd_byte = pc;
      scfg_pkg::ADR_VARIANT_ID: rd_byte = scfg_pkg::VARIANT_ID_DEF;
      scfg_pkg::ADR_READBACK_SEL: rd_byte = rb;
      scfg_pkg::ADR_OSC_DIV: rd_byte = act ? ad : bd;
      scfg_pkg::ADR_CLK_IN_SEL: rd_byte = act ? ac : bc;
      scfg_pkg::ADR_PWRDN_SYNC: rd_byte = act ? ap : bp;
      scfg_pkg::ADR_COMMIT: rd_byte = {7'h00, cm};
      default: rd_byte = 8'h00; // spare and unmapped read zero
    endcase
  endfunction

  assign lsb_first = pcfg_r[scfg_pkg::BIT_LSB_FIRST];

  // serial engine and register bank
  always_comb begin
    state_nxt = state_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    bcnt_nxt = bcnt_r;
    rd_nxt = rd_r;
    len_nxt = len_r;
    bidx_nxt = bidx_r;
    addr_nxt = addr_r;
    tx_nxt = tx_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    pcfg_nxt = pcfg_r;
    rbsel_nxt = rbsel_r;
    bdiv_nxt = bdiv_r;
    bclk_nxt = bclk_r;
    bpwr_nxt = bpwr_r;
    adiv_nxt = adiv_r;
    aclk_nxt = aclk_r;
    apwr_nxt = apwr_r;
    commit_nxt = 1'b0; // self-clearing one cycle after a write
    // bits enter at the end chosen by the bit order
    ins = lsb_first ? {sdio_s, sh_r[15:1]} : {sh_r[14:0], sdio_s};
    rx = lsb_first ? {sdio_s, sh_r[7:1]} : {sh_r[6:0], sdio_s};
    if (commit_r) begin
      adiv_nxt = bdiv_r;
      aclk_nxt = bclk_r;
      apwr_nxt = bpwr_r;
    end
    if (cs_n_s) begin
      state_nxt = scfg_pkg::ST_IDLE;
      oe_nxt = 1'b0;
      cnt_nxt = 4'h0;
    end else begin
      unique case (state_r)
        scfg_pkg::ST_IDLE: begin
          state_nxt = scfg_pkg::ST_INSTR;
          cnt_nxt = 4'h0;
        end
        scfg_pkg::ST_INSTR: begin
          // always a 16-bit instruction, whatever the length bit says
          if (sclk_rise) begin
            sh_nxt = ins;
            cnt_nxt = 4'(cnt_r + 4'h1);
            if (cnt_r == 4'(scfg_pkg::INSTR_LEN - 1)) begin
              state_nxt = scfg_pkg::ST_DATA;
              rd_nxt = ins[scfg_pkg::INS_RD];
              len_nxt = ins[scfg_pkg::INS_LEN_HI:scfg_pkg::INS_LEN_LO];
              addr_nxt = ins[12:0];
              bcnt_nxt = 3'h0;
              bidx_nxt = 2'h0;
              tx_nxt = rd_byte(ins[12:0], rbsel_r[scfg_pkg::BIT_RB_ACTIVE],
                pcfg_r, rbsel_r, bdiv_r, bclk_r, bpwr_r, adiv_r, aclk_r,
                apwr_r, commit_r);
            end
          end
        end
        scfg_pkg::ST_DATA: begin
          if (sclk_fall && rd_r) begin
            out_nxt = lsb_first ? tx_r[bcnt_r] : tx_r[3'(7 - bcnt_r)];
            oe_nxt = 1'b1;
          end
          if (sclk_rise) begin
            sh_nxt = {8'h00, rx};
            bcnt_nxt = 3'(bcnt_r + 3'h1);
            if (bcnt_r == 3'h7) begin
              if (!rd_r) begin
                unique case (addr_r)
                  scfg_pkg::ADR_PORT_CFG: pcfg_nxt = rx;
                  scfg_pkg::ADR_READBACK_SEL: rbsel_nxt = rx;
                  scfg_pkg::ADR_OSC_DIV: bdiv_nxt = rx;
                  scfg_pkg::ADR_CLK_IN_SEL: bclk_nxt = rx;
                  scfg_pkg::ADR_PWRDN_SYNC: bpwr_nxt = rx;
                  scfg_pkg::ADR_COMMIT:
                    commit_nxt = rx[scfg_pkg::BIT_COMMIT];
                  default: ; // identification is read-only
                endcase
              end
              addr_nxt = step_addr(addr_r, lsb_first);
              bidx_nxt = 2'(bidx_r + 2'h1);
              tx_nxt = rd_byte(step_addr(addr_r, lsb_first),
                rbsel_r[scfg_pkg::BIT_RB_ACTIVE], pcfg_r, rbsel_r, bdiv_r,
                bclk_r, bpwr_r, adiv_r, aclk_r, apwr_r, commit_r);
              if (len_r != scfg_pkg::LEN_STREAM && bidx_r == len_r) begin
                state_nxt = scfg_pkg::ST_DONE;
              end
            end
          end
        end
        scfg_pkg::ST_DONE: begin
          // extra clocks past the byte count are ignored
          if (sclk_fall) begin
            oe_nxt = 1'b0;
          end
        end
      endcase
    end
    // soft reset holds every other register at its default
    if (pcfg_nxt[scfg_pkg::BIT_SOFT_RST]) begin
      rbsel_nxt = scfg_pkg::RST_READBACK_SEL;
      bdiv_nxt = scfg_pkg::RST_OSC_DIV;
      bclk_nxt = scfg_pkg::RST_CLK_IN_SEL;
      bpwr_nxt = scfg_pkg::RST_PWRDN_SYNC;
      adiv_nxt = scfg_pkg::RST_OSC_DIV;
      aclk_nxt = scfg_pkg::RST_CLK_IN_SEL;
      apwr_nxt = scfg_pkg::RST_PWRDN_SYNC;
      commit_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= scfg_pkg::ST_IDLE;
      sh_r <= 16'h0000;
      cnt_r <= 4'h0;
      bcnt_r <= 3'h0;
      rd_r <= 1'b0;
      len_r <= 2'h0;
      bidx_r <= 2'h0;
      addr_r <= 13'h0000;
      tx_r <= 8'h00;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      pcfg_r <= scfg_pkg::RST_PORT_CFG; // long instruction set
      rbsel_r <= scfg_pkg::RST_READBACK_SEL;
      bdiv_r <= scfg_pkg::RST_OSC_DIV;
      bclk_r <= scfg_pkg::RST_CLK_IN_SEL;
      bpwr_r <= scfg_pkg::RST_PWRDN_SYNC;
      adiv_r <= scfg_pkg::RST_OSC_DIV;
      aclk_r <= scfg_pkg::RST_CLK_IN_SEL;
      apwr_r <= scfg_pkg::RST_PWRDN_SYNC;
      commit_r <= 1'b0;
      SDIO_O <= 1'b0;
      SDIO_OE_O <= 1'b0;
      SDO_O <= 1'b0;
      SDO_OE_O <= 1'b0;
      OSC_DIV_O <= scfg_pkg::RST_OSC_DIV;
      CLK_IN_O <= scfg_pkg::RST_CLK_IN_SEL;
      PWRDN_O <= scfg_pkg::RST_PWRDN_SYNC;
    end else begin
      state_r <= state_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      bcnt_r <= bcnt_nxt;
      rd_r <= rd_nxt;
      len_r <= len_nxt;
      bidx_r <= bidx_nxt;
      addr_r <= addr_nxt;
      tx_r <= tx_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      pcfg_r <= pcfg_nxt;
      rbsel_r <= rbsel_nxt;
      bdiv_r <= bdiv_nxt;
      bclk_r <= bclk_nxt;
      bpwr_r <= bpwr_nxt;
      adiv_r <= adiv_nxt;
      aclk_r <= aclk_nxt;
      apwr_r <= apwr_nxt;
      commit_r <= commit_nxt;
      // pins lag the engine by one cycle, still well inside a half period
      SDIO_O <= out_r;
      SDIO_OE_O <= oe_r & ~pcfg_r[scfg_pkg::BIT_PIN_MODE];
      SDO_O <= out_r;
      SDO_OE_O <= oe_r & pcfg_r[scfg_pkg::BIT_PIN_MODE];
      OSC_DIV_O <= adiv_r;
      CLK_IN_O <= aclk_r;
      PWRDN_O <= apwr_r;
    end
  end
endmodule
`default_nettype wire

// ---- tb/scfg_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// pin-level watch; the register file itself stays out of sight
module scfg_checker (
  input wire logic CLK_I, // system clock
  input wire logic RST_N_I, // sync reset
  input wire logic CS_N_I, // chip select
  input wire logic SDIO_O, // shared pin value
  input wire logic SDIO_OE_O, // shared pin enable
  input wire logic SDO_O, // dedicated pin value
  input wire logic SDO_OE_O, // dedicated pin enable
  input wire logic [7:0] OSC_DIV_O, // active divide ratio
  input wire logic [7:0] CLK_IN_O, // active input select
  input wire logic [7:0] PWRDN_O // active power-down
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // long deselect: no transfer or commit can still be pending
  sequence s_idle; CS_N_I [*8]; endsequence
  sequence s_read; $rose(SDIO_OE_O) || $rose(SDO_OE_O); endsequence
  AST_ONE_PIN: assert property (!(SDIO_OE_O && SDO_OE_O))
    else $error("both data pins driven");
  AST_IDLE_FLOAT: assert property (s_idle |-> !SDIO_OE_O && !SDO_OE_O)
    else $error("pin driven while deselected");
  AST_IDLE_HOLD: assert property
    (s_idle |=> $stable({OSC_DIV_O, CLK_IN_O, PWRDN_O}))
    else $error("active copy moved while deselected");
  AST_RST_VAL: assert property ($rose(RST_N_I) |->
    OSC_DIV_O == 8'h02 && CLK_IN_O == 8'h00 && PWRDN_O == 8'h00)
    else $error("active copy not at default after reset");
  AST_RST_OE: assert property ($rose(RST_N_I) |-> !SDIO_OE_O && !SDO_OE_O)
    else $error("pin driven after reset");
  AST_READ_SEL: assert property (s_read |-> !$past(CS_N_I))
    else $error("read drive without select");
  AST_READ_HOLD: assert property ($rose(SDIO_OE_O) |=> SDIO_OE_O [*7])
    else $error("shared pin drive too short");
  AST_SDO_HOLD: assert property ($rose(SDO_OE_O) |=> SDO_OE_O [*7])
    else $error("dedicated pin drive too short");
  AST_SDO_BIT: assert property
    (SDO_OE_O && $changed(SDO_O) |=> $stable(SDO_O) [*6])
    else $error("dedicated pin bit too short");
endmodule
bind scfg_port scfg_checker scfg_checker_i (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .CS_N_I(CS_N_I), .SDIO_O(SDIO_O),
  .SDIO_OE_O(SDIO_OE_O), .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O),
  .OSC_DIV_O(OSC_DIV_O), .CLK_IN_O(CLK_IN_O), .PWRDN_O(PWRDN_O));
`default_nettype wire

// ---- tb/scfg_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// serial host: link moves on system edges, 8 clocks a bit
module scfg_host (
  input wire logic clk_i, // system clock
  input wire logic sdio_i, // device shared pin value
  input wire logic sdio_oe_i, // device shared pin enable
  input wire logic sdo_i, // device dedicated pin value
  input wire logic sdo_oe_i, // device dedicated pin enable
  output logic sclk_o, // serial clock, idle low
  output logic cs_n_o, // chip select
  output logic sdio_w_o // resolved shared pin level
);
  logic drv = 1'b0;
  logic dq = 1'b0;
  logic lsb = 1'b0;
  logic sep = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // no pull on the wire: a released pin shows the inverse of its last bit
  assign sdio_w_o = sdio_oe_i ? sdio_i : (drv ? dq : ~dq);
  // fall, drive, rise; sample late so a slow read bit still lands
  task automatic sh(input logic d, input logic en, output logic q);
    @(posedge clk_i);
    sclk_o <= 1'b0;
    dq <= d;
    drv <= en;
    repeat (4) @(posedge clk_i);
    sclk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    q = sep ? (sdo_oe_i ? sdo_i : ~sdo_i) : sdio_w_o;
  endtask
  // byte k of d goes to or comes from the k-th address of the walk
  task automatic xfer(input logic rd, input logic [1:0] len,
      input logic [12:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [15:0] w;
    logic b;
    int p;
    w = {rd, len, a};
    q = 16'h0000;
    if (!rd && a == 13'h000) begin
      d[3] = 1'b1;
      d[7:4] = {d[0], d[1], d[2], d[3]};
    end
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < 16; i++) sh(w[lsb ? i : 15 - i], 1'b1, b);
    // stream count sends two bytes, then deselect ends the transfer
    for (int i = 0; i < 8 * (len == 2'h3 ? 2 : len + 1); i++) begin
      p = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
      sh(d[p], !rd, b);
      q[p] = b;
    end
    @(posedge clk_i);
    sclk_o <= 1'b0;
    drv <= 1'b0;
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    if (!rd && a == 13'h000) begin
      lsb = d[1];
      sep = d[0];
    end
    // hand back off the edge so callers sample settled outputs
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/test_serial_port_config_registers.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_config_registers;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, sdio_w, sdio, sdio_oe, dedicated_read_out_pin, sdo_oe;
  logic [7:0] osc, cin, pwr;
  logic [15:0] q;
  int fails = 0;
  int checks_done = 0;
  // 50 MHz system clock
  always #10 clk = ~clk;
  scfg_port scfg_port_i (.CLK_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk),
    .CS_N_I(cs_n), .SDIO_I(sdio_w), .SDIO_O(sdio), .SDIO_OE_O(sdio_oe),
    .SDO_O(dedicated_read_out_pin), .SDO_OE_O(sdo_oe), .OSC_DIV_O(osc), .CLK_IN_O(cin),
    .PWRDN_O(pwr));
  scfg_host scfg_host_i (.clk_i(clk), .sdio_i(sdio), .sdio_oe_i(sdio_oe),
    .sdo_i(dedicated_read_out_pin), .sdo_oe_i(sdo_oe), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdio_w_o(sdio_w));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // compare away from the clock edge so no update race decides it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    @(negedge clk);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    scfg_host_i.xfer(1'b0, 2'h0, a, {8'h00, d}, q);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    scfg_host_i.xfer(1'b1, 2'h0, a, 16'h0000, q);
    chk(q, {8'h00, e});
  endtask
  // tests in order; bit order and pin mode carry over between them
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({osc, pwr}, 16'h0200);
    rd(13'h003, scfg_pkg::VARIANT_ID_DEF);
    wr(13'h003, 8'ha5);
    rd(13'h003, scfg_pkg::VARIANT_ID_DEF);
    wr(13'h231, 8'hff);
    rd(13'h231, 8'h00);
    $display("test id done");
    wr(13'h1e0, 8'h07);
    chk({8'h00, osc}, 16'h0002);
    rd(13'h1e0, 8'h07);
    wr(13'h004, 8'h01);
    rd(13'h1e0, 8'h02);
    wr(13'h232, 8'h01);
    chk({8'h00, osc}, 16'h0007);
    rd(13'h232, 8'h00);
    wr(13'h004, 8'h00);
    $display("test readback done");
    scfg_host_i.xfer(1'b0, 2'h1, 13'h1e1, 16'h0b03, q);
    wr(13'h232, 8'h01);
    chk({osc, cin}, 16'h0b03);
    wr(13'h000, 8'h02);
    scfg_host_i.xfer(1'b0, 2'h1, 13'h1e0, 16'h0c04, q);
    wr(13'h232, 8'h01);
    chk({osc, cin}, 16'h040c);
    scfg_host_i.xfer(1'b1, 2'h1, 13'h1e0, 16'h0000, q);
    chk(q, 16'h0c04);
    $display("test bit order done");
    wr(13'h000, 8'h01);
    rd(13'h003, scfg_pkg::VARIANT_ID_DEF);
    wr(13'h000, 8'h04);
    chk({osc, cin}, 16'h0200);
    wr(13'h000, 8'h00);
    rd(13'h1e0, 8'h02);
    $display("test soft reset done");
    // stream count: spare byte dropped, next address down takes the second
    scfg_host_i.xfer(1'b0, 2'h3, 13'h231, 16'h0600, q);
    wr(13'h232, 8'h01);
    chk({8'h00, pwr}, 16'h0006);
    $display("test stream done");
    test_done;
  end
  // about 5400 clocks expected; cut a hang well beyond that
  initial begin
    #400us;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
